// ### verilog/gotr_regs.sv
// register bank: per-axis rate bias, spare trim bytes, built-in self-test
// assumes an 8-bit register port from the serial interface, one clock
`timescale 1ns/10ps
// What this block does
// - subtract each axis's 12-bit bias from filtered and unfiltered rate data
// - x bias high register holds bits 11:8 high nibble, 7:4 low, resets zero
// - y bias high register holds bits 11:8 high nibble, 7:4 low, resets zero
// - z bias high register holds bits 11:8 high nibble, 7:4 low, resets zero
// - reload every axis bias from non-volatile image after power-on or soft reset
// - host writes to bias fields take effect immediately in the subtraction
// - spare low register: x bits 1:0 at 3:2, y bit0 at 1, z bit0 at 0
// - upper nibble of spare low register is spare, saved and restored
// - spare byte register is plain storage, saved and restored
// - spare registers have no fixed reset value; they come from the image
// - writing one to self-test bit 0 starts a self-test
// - ready flag bit 1 set at completion; fail bit 2 zero means pass
// - ready and fail both one reports out-of-range sensor values
// - rate-valid bit 4 shows proper function continuously, no trigger needed
// - image load trigger refreshes all trim registers, only when image ready
// - bias low bits x 3:2 and y 3:1 live in the preceding register
module gotr_regs
  import gotr_pkg::*;
#(
  parameter int ST_CYCLES = SELF_TEST_CYCLES,
  parameter int RW        = RATE_WIDTH
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          soft_reset_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  output logic      [7:0]    reg_rdata_o,
  input  wire logic [7:0]    bias_low_a_i,
  input  wire logic          nvm_ready_i,
  input  wire logic          nvm_wr_i,
  input  wire logic [2:0]    nvm_wr_addr_i,
  input  wire logic [7:0]    nvm_wr_data_i,
  input  wire logic [RW-1:0] rate_filt_x_i,
  input  wire logic [RW-1:0] rate_filt_y_i,
  input  wire logic [RW-1:0] rate_filt_z_i,
  input  wire logic [RW-1:0] rate_raw_x_i,
  input  wire logic [RW-1:0] rate_raw_y_i,
  input  wire logic [RW-1:0] rate_raw_z_i,
  input  wire logic          sensor_ok_i,
  input  wire logic          st_result_fail_i,
  output logic      [RW-1:0] comp_filt_x_o,
  output logic      [RW-1:0] comp_filt_y_o,
  output logic      [RW-1:0] comp_filt_z_o,
  output logic      [RW-1:0] comp_raw_x_o,
  output logic      [RW-1:0] comp_raw_y_o,
  output logic      [RW-1:0] comp_raw_z_o,
  output logic               self_test_run_o,
  output logic               load_busy_o
);
  if (ST_CYCLES < 1 || ST_CYCLES > 65535) begin : g_cycles_check
    $error("gotr_regs: ST_CYCLES out of range");
  end
  if (RW < BIAS_WIDTH) begin : g_width_check
    $error("gotr_regs: rate width below bias width");
  end
  if (NVM_WORDS < 5 || NVM_WORDS > 8) begin : g_image_check
    $error("gotr_regs: image must hold five to eight words");
  end

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  logic [7:0] x_axis_bias_high;
  logic [7:0] y_axis_bias_high;
  logic [7:0] z_axis_bias_high;
  logic [7:0] spare_trim_and_bias_low;
  logic [7:0] spare_trim_byte;
  logic       st_ready;
  logic       st_fail;
  logic       rate_ok;
  logic [15:0] st_count;
  gotr_st_state_t st_state;

  // --------------------------------------------------------------------------
  // image load sequencer
  // --------------------------------------------------------------------------
  logic       load_active;
  logic [2:0] load_idx;
  logic       load_data_ok;
  logic [2:0] load_dest;
  logic [7:0] img_data;

  wire wr_x     = reg_wr_i && reg_addr_i == ADDR_X_BIAS_HIGH;
  wire wr_y     = reg_wr_i && reg_addr_i == ADDR_Y_BIAS_HIGH;
  wire wr_z     = reg_wr_i && reg_addr_i == ADDR_Z_BIAS_HIGH;
  wire wr_low   = reg_wr_i && reg_addr_i == ADDR_SPARE_LOW;
  wire wr_byte  = reg_wr_i && reg_addr_i == ADDR_SPARE_BYTE;
  wire wr_st    = reg_wr_i && reg_addr_i == ADDR_SELF_TEST;
  wire wr_nvm   = reg_wr_i && reg_addr_i == ADDR_NVM_CTRL;
  wire load_req = (wr_nvm && reg_wdata_i[NVM_LOAD_BIT] && nvm_ready_i)
                  || soft_reset_i;
  wire st_trig  = wr_st && reg_wdata_i[ST_TRIG_BIT];
  wire last_idx = load_idx == 3'd4;

  gotr_nvm_image #(
    .WORDS (NVM_WORDS)
  ) u_image (
    .clock_i   (clock_i),
    .wr_en_i   (nvm_wr_i),
    .wr_addr_i (nvm_wr_addr_i),
    .wr_data_i (nvm_wr_data_i),
    .rd_addr_i (load_idx),
    .rd_data_o (img_data)
  );

  // image word k lands on register k: x, y, z, spare low, spare byte
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      load_active  <= 1'b1;
      load_idx     <= 3'd0;
      load_data_ok <= 1'b0;
      load_dest    <= 3'd0;
    end else begin
      load_data_ok <= load_active;
      load_dest    <= load_idx;
      if (load_req && !load_active) begin
        load_active <= 1'b1;
        load_idx    <= 3'd0;
      end else if (load_active) begin
        load_active <= !last_idx;
        load_idx    <= last_idx ? 3'd0 : load_idx + 3'd1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // trim registers
  // --------------------------------------------------------------------------
  wire ld_x    = load_data_ok && load_dest == 3'd0;
  wire ld_y    = load_data_ok && load_dest == 3'd1;
  wire ld_z    = load_data_ok && load_dest == 3'd2;
  wire ld_low  = load_data_ok && load_dest == 3'd3;
  wire ld_byte = load_data_ok && load_dest == 3'd4;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      x_axis_bias_high <= BIAS_RESET;
    end else if (ld_x) begin
      x_axis_bias_high <= img_data;
    end else if (wr_x) begin
      x_axis_bias_high <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      y_axis_bias_high <= BIAS_RESET;
    end else if (ld_y) begin
      y_axis_bias_high <= img_data;
    end else if (wr_y) begin
      y_axis_bias_high <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      z_axis_bias_high <= BIAS_RESET;
    end else if (ld_z) begin
      z_axis_bias_high <= img_data;
    end else if (wr_z) begin
      z_axis_bias_high <= reg_wdata_i;
    end
  end

  // spare registers take no reset: their value after reset comes from the image, later host writes replace it
  always_ff @(posedge clock_i) begin
    if (ld_low) begin
      spare_trim_and_bias_low <= img_data;
    end else if (wr_low) begin
      spare_trim_and_bias_low <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (ld_byte) begin
      spare_trim_byte <= img_data;
    end else if (wr_byte) begin
      spare_trim_byte <= reg_wdata_i;
    end
  end

  // --------------------------------------------------------------------------
  // bias assembly and subtraction
  // --------------------------------------------------------------------------
  wire [BIAS_WIDTH-1:0] bias_x = {x_axis_bias_high, bias_low_a_i[7:6],
                                  spare_trim_and_bias_low[3:2]};
  wire [BIAS_WIDTH-1:0] bias_y = {y_axis_bias_high, bias_low_a_i[5:3],
                                  spare_trim_and_bias_low[1]};
  wire [BIAS_WIDTH-1:0] bias_z = {z_axis_bias_high, bias_low_a_i[2:0],
                                  spare_trim_and_bias_low[0]};

  function automatic logic [RW-1:0] sub_bias(input logic [RW-1:0] rate,
                                             input logic [BIAS_WIDTH-1:0] b);
    logic [RW-1:0] ext;
    ext      = {{(RW-BIAS_WIDTH){b[BIAS_WIDTH-1]}}, b};
    sub_bias = rate - ext;
  endfunction

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      comp_filt_x_o <= '0;
      comp_filt_y_o <= '0;
      comp_filt_z_o <= '0;
    end else begin
      comp_filt_x_o <= sub_bias(rate_filt_x_i, bias_x);
      comp_filt_y_o <= sub_bias(rate_filt_y_i, bias_y);
      comp_filt_z_o <= sub_bias(rate_filt_z_i, bias_z);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      comp_raw_x_o <= '0;
      comp_raw_y_o <= '0;
      comp_raw_z_o <= '0;
    end else begin
      comp_raw_x_o <= sub_bias(rate_raw_x_i, bias_x);
      comp_raw_y_o <= sub_bias(rate_raw_y_i, bias_y);
      comp_raw_z_o <= sub_bias(rate_raw_z_i, bias_z);
    end
  end

  // --------------------------------------------------------------------------
  // self-test
  // --------------------------------------------------------------------------
  wire st_done = st_state == GOTR_ST_RUN && st_count == 16'(ST_CYCLES - 1);

  // rate-valid follows the sensor flag one cycle later
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rate_ok <= 1'b0;
    end else begin
      rate_ok <= sensor_ok_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_state <= GOTR_ST_IDLE;
      st_count <= 16'h0000;
      st_ready <= 1'b0;
      st_fail  <= 1'b0;
    end else begin
      unique case (st_state)
        GOTR_ST_IDLE: begin
          if (st_trig) begin
            st_state <= GOTR_ST_RUN;
            st_count <= 16'h0000;
            st_ready <= 1'b0;
            st_fail  <= 1'b0;
          end
        end
        GOTR_ST_RUN: begin
          st_count <= st_count + 16'h0001;
          if (st_done) begin
            st_state <= GOTR_ST_IDLE;
            st_ready <= 1'b1;
            st_fail  <= st_result_fail_i;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // read path and status outputs
  // --------------------------------------------------------------------------
  wire [7:0] st_read = {3'b000, rate_ok, 1'b0, st_fail, st_ready, 1'b0};
  wire [7:0] rd_mux  =
      reg_addr_i == ADDR_X_BIAS_HIGH ? x_axis_bias_high :
      reg_addr_i == ADDR_Y_BIAS_HIGH ? y_axis_bias_high :
      reg_addr_i == ADDR_Z_BIAS_HIGH ? z_axis_bias_high :
      reg_addr_i == ADDR_SPARE_LOW   ? spare_trim_and_bias_low :
      reg_addr_i == ADDR_SPARE_BYTE  ? spare_trim_byte :
      reg_addr_i == ADDR_SELF_TEST   ? st_read : 8'h00;

  // read data stands until the next read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      self_test_run_o <= 1'b0;
      load_busy_o     <= 1'b1;
    end else begin
      self_test_run_o <= st_state == GOTR_ST_RUN;
      load_busy_o     <= load_active || load_data_ok;
    end
  end
endmodule

// ### verilog/gotr_pkg.sv
// package for the rate-sensor offset, spare trim and self-test register bank
// assumes one 50 MHz clock and an 8-bit register port of the serial interface
package gotr_pkg;
  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_NVM_CTRL     = 8'h33;
  localparam logic [7:0] ADDR_BIAS_LOW_A   = 8'h36;
  localparam logic [7:0] ADDR_X_BIAS_HIGH  = 8'h37;
  localparam logic [7:0] ADDR_Y_BIAS_HIGH  = 8'h38;
  localparam logic [7:0] ADDR_Z_BIAS_HIGH  = 8'h39;
  localparam logic [7:0] ADDR_SPARE_LOW    = 8'h3a;
  localparam logic [7:0] ADDR_SPARE_BYTE   = 8'h3b;
  localparam logic [7:0] ADDR_SELF_TEST    = 8'h3c;
  // --------------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------------
  localparam int         NVM_LOAD_BIT      = 3;
  localparam int         NVM_READY_BIT     = 2;
  localparam int         ST_TRIG_BIT       = 0;
  localparam int         ST_READY_BIT      = 1;
  localparam int         ST_FAIL_BIT       = 2;
  localparam int         ST_RATE_OK_BIT    = 4;
  localparam logic [7:0] BIAS_RESET        = 8'h00;
  localparam logic [7:0] SELF_TEST_RESET   = 8'h00;
  localparam int         BIAS_WIDTH        = 12;
  localparam int         RATE_WIDTH        = 16;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int         CLOCK_MHZ         = 50;
  localparam int         SELF_TEST_US      = 20;
  localparam int         SELF_TEST_CYCLES  = SELF_TEST_US * CLOCK_MHZ;
  localparam int         NVM_WORDS         = 8;
  // --------------------------------------------------------------------------
  // self-test sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    GOTR_ST_IDLE = 2'b01,
    GOTR_ST_RUN  = 2'b10
  } gotr_st_state_t;
endpackage

// ### verilog/gotr_nvm_image.sv
// non-volatile image of the trim registers, one byte per word
// assumes the programming controller outside writes it through the write port
`timescale 1ns/10ps
module gotr_nvm_image
  import gotr_pkg::*;
#(
  parameter int WORDS = NVM_WORDS
) (
  input  wire logic                     clock_i,
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(WORDS)-1:0] wr_addr_i,
  input  wire logic [7:0]               wr_data_i,
  input  wire logic [$clog2(WORDS)-1:0] rd_addr_i,
  output logic      [7:0]               rd_data_o
);
  if (WORDS < 2) begin : g_words_check
    $error("gotr_nvm_image needs at least two words");
  end

  logic [7:0] mem [WORDS];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ### tb/gotr_regs_props.sv
// assertions on the ports of the rate bias, spare trim and self-test register bank
// assumes one clock, synchronous reset and a short self-test count
`timescale 1ns/10ps
module gotr_regs_props
  import gotr_pkg::*;
#(
  parameter int ST_CYCLES = SELF_TEST_CYCLES,
  parameter int RW        = RATE_WIDTH
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          soft_reset_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic [7:0]    reg_rdata_o,
  input  wire logic          nvm_ready_i,
  input  wire logic          sensor_ok_i,
  input  wire logic [RW-1:0] rate_filt_x_i,
  input  wire logic [RW-1:0] rate_raw_x_i,
  input  wire logic [RW-1:0] comp_filt_x_o,
  input  wire logic [RW-1:0] comp_raw_x_o,
  input  wire logic          self_test_run_o,
  input  wire logic          load_busy_o
);
  // --------------------------------------------------------------------------
  // decodes and run length counter
  // --------------------------------------------------------------------------
  logic [15:0] run_cnt;
  wire         wr_x  = reg_wr_i && reg_addr_i == ADDR_X_BIAS_HIGH;
  wire         rd_x  = reg_rd_i && reg_addr_i == ADDR_X_BIAS_HIGH;
  wire         rd_st = reg_rd_i && reg_addr_i == ADDR_SELF_TEST;
  wire         trig  = reg_wr_i && reg_addr_i == ADDR_SELF_TEST && reg_wdata_i[ST_TRIG_BIT];
  wire         load  = reg_wr_i && reg_addr_i == ADDR_NVM_CTRL && reg_wdata_i[NVM_LOAD_BIT]
                       && !load_busy_o;
  always_ff @(posedge clock_i) begin
    if (rst_i || !self_test_run_o) begin
      run_cnt <= '0;
    end else begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  bias_readback_a: assert property (wr_x && !load_busy_o ##1 !reg_wr_i ##1 rd_x
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("bias readback wrong");
  comp_pair_a: assert property (!$past(rst_i) && !load_busy_o
    |-> RW'(comp_filt_x_o - comp_raw_x_o) == RW'($past(rate_filt_x_i - rate_raw_x_i)))
    else $error("paths use unequal bias");
  st_start_a: assert property (trig && !self_test_run_o && !load_busy_o
    |-> ##[1:2] self_test_run_o) else $error("self-test did not start");
  st_length_a: assert property ($fell(self_test_run_o) && !$past(rst_i)
    |-> run_cnt >= ST_CYCLES - 1 && run_cnt <= ST_CYCLES + 1) else $error("bad test length");
  ready_clear_a: assert property (trig && !self_test_run_o ##2 rd_st
    |=> !reg_rdata_o[ST_READY_BIT]) else $error("ready not cleared by trigger");
  rate_ok_a: assert property (rd_st && !$past(rst_i)
    |=> reg_rdata_o[ST_RATE_OK_BIT] == $past(sensor_ok_i, 2)) else $error("rate ok wrong");
  st_reserved_a: assert property (rd_st |=> reg_rdata_o[7:5] == 3'h0
    && !reg_rdata_o[3] && !reg_rdata_o[ST_TRIG_BIT]) else $error("self-test bits not zero");
  load_refuse_a: assert property (load && !nvm_ready_i |=> !load_busy_o)
    else $error("load taken while image not ready");
  load_run_a: assert property (load && nvm_ready_i
    |-> ##2 load_busy_o ##[1:10] !load_busy_o) else $error("load not run");
  soft_load_a: assert property (soft_reset_i && !load_busy_o
    |-> ##[1:2] load_busy_o ##[1:10] !load_busy_o) else $error("soft reset no reload");
  cover property ($fell(self_test_run_o));
  cover property (load && nvm_ready_i);
  cover property (soft_reset_i);
endmodule
bind gotr_regs gotr_regs_props #(.ST_CYCLES(ST_CYCLES), .RW(RW)) gotr_regs_props_inst (
  .clock_i(clock_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .nvm_ready_i(nvm_ready_i), .sensor_ok_i(sensor_ok_i),
  .rate_filt_x_i(rate_filt_x_i), .rate_raw_x_i(rate_raw_x_i), .comp_filt_x_o(comp_filt_x_o),
  .comp_raw_x_o(comp_raw_x_o), .self_test_run_o(self_test_run_o), .load_busy_o(load_busy_o)
);

// ### tb/tb.sv
// self-checking bench for the rate bias, spare trim and self-test register bank
// assumes the checker is bound to gotr_regs by its own file
`timescale 1ns/10ps
module tb
  import gotr_pkg::*;
;
  // --------------------------------------------------------------------------
  // stimulus, design and closing
  // --------------------------------------------------------------------------
  logic        clock_i = 1'b0, rst_i = 1'b1, soft_reset_i = 1'b0, reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0, nvm_ready_i = 1'b0, nvm_wr_i = 1'b0, sensor_ok_i = 1'b0;
  logic        st_result_fail_i = 1'b0, self_test_run_o, load_busy_o;
  logic [2:0]  nvm_wr_addr_i = '0;
  logic [7:0]  reg_addr_i = '0, reg_wdata_i = '0, nvm_wr_data_i = '0, bias_low_a_i = '0;
  logic [7:0]  reg_rdata_o;
  logic [7:0]  img [5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
  logic [15:0] rf [3] = '{default: '0}, rr [3] = '{default: '0}, cf [3], cr [3];
  int          failures = 0, n_tests = 0, cycles = 0;
  gotr_regs #(.ST_CYCLES(5)) gotr_regs_inst (
    .clock_i(clock_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .bias_low_a_i(bias_low_a_i), .nvm_ready_i(nvm_ready_i),
    .nvm_wr_i(nvm_wr_i), .nvm_wr_addr_i(nvm_wr_addr_i), .nvm_wr_data_i(nvm_wr_data_i),
    .rate_filt_x_i(rf[0]), .rate_filt_y_i(rf[1]), .rate_filt_z_i(rf[2]),
    .rate_raw_x_i(rr[0]), .rate_raw_y_i(rr[1]), .rate_raw_z_i(rr[2]),
    .sensor_ok_i(sensor_ok_i), .st_result_fail_i(st_result_fail_i),
    .comp_filt_x_o(cf[0]), .comp_filt_y_o(cf[1]), .comp_filt_z_o(cf[2]),
    .comp_raw_x_o(cr[0]), .comp_raw_y_o(cr[1]), .comp_raw_z_o(cr[2]),
    .self_test_run_o(self_test_run_o), .load_busy_o(load_busy_o)
  );
  always #10 clock_i = ~clock_i;
  task automatic complete_run();
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 check(what, {8'h00, reg_rdata_o}, {8'h00, exp});
  endtask
  task automatic wait_idle();
    int i = 0;
    repeat (2) @(posedge clock_i);
    #1;
    while ((load_busy_o !== 1'b0 || self_test_run_o !== 1'b0) && i < 40) begin
      @(posedge clock_i);
      #1 i++;
    end
    check("idle wait", 16'(i == 40), 16'h0000);
  endtask
  task automatic t_reset_load();
    for (int w = 0; w < 5; w++) begin
      @(posedge clock_i);
      nvm_wr_i <= 1'b1;
      nvm_wr_addr_i <= 3'(w);
      nvm_wr_data_i <= img[w];
      if (w == 4) rst_i <= 1'b0;
    end
    @(posedge clock_i);
    nvm_wr_i <= 1'b0;
    wait_idle();
    for (int w = 0; w < 5; w++) rd(ADDR_X_BIAS_HIGH + 8'(w), img[w], "reload");
    rd(ADDR_SELF_TEST, SELF_TEST_RESET, "self-test reset");
  endtask
  task automatic t_readwrite();
    for (int w = 0; w < 5; w++) begin
      wr(ADDR_X_BIAS_HIGH + 8'(w), ~img[w]);
      rd(ADDR_X_BIAS_HIGH + 8'(w), ~img[w], "readback");
    end
    wr(ADDR_SELF_TEST, 8'hee);
    rd(ADDR_SELF_TEST, 8'h00, "self-test write-only");
    rd(8'h40, 8'h00, "unmapped");
  endtask
  task automatic t_bias();
    logic [15:0] ef [3] = '{16'hf801, 16'h07f1, 16'h00f1};
    logic [15:0] er [3] = '{16'hf811, 16'h0801, 16'h0101};
    @(posedge clock_i);
    rf <= '{16'h0000, 16'h0000, 16'h0100};
    rr <= '{16'h0010, 16'h0010, 16'h0110};
    bias_low_a_i <= 8'hff;
    wr(ADDR_SPARE_LOW, 8'h0f);
    wr(ADDR_X_BIAS_HIGH, 8'h7f);
    wr(ADDR_Y_BIAS_HIGH, 8'h80);
    wr(ADDR_Z_BIAS_HIGH, 8'h00);
    repeat (2) @(posedge clock_i);
    #1;
    for (int i = 0; i < 3; i++) begin
      check("filtered rate", cf[i], ef[i]);
      check("raw rate", cr[i], er[i]);
    end
  endtask
  task automatic t_self_test();
    for (int f = 0; f < 2; f++) begin
      @(posedge clock_i);
      st_result_fail_i <= f[0];
      sensor_ok_i <= ~f[0];
      wr(ADDR_SELF_TEST, 8'h01);
      rd(ADDR_SELF_TEST, {3'h0, ~f[0], 4'h0}, "self-test running");
      wait_idle();
      rd(ADDR_SELF_TEST, {3'h0, ~f[0], 1'b0, f[0], 2'h2}, "self-test result");
    end
  endtask
  task automatic t_load_soft();
    @(posedge clock_i);
    nvm_wr_i <= 1'b1;
    nvm_wr_addr_i <= 3'h4;
    nvm_wr_data_i <= 8'h5a;
    @(posedge clock_i);
    nvm_wr_i <= 1'b0;
    wr(ADDR_NVM_CTRL, 8'h08);
    wait_idle();
    rd(ADDR_SPARE_BYTE, ~img[4], "load refused");
    @(posedge clock_i);
    nvm_ready_i <= 1'b1;
    wr(ADDR_NVM_CTRL, 8'h08);
    wait_idle();
    rd(ADDR_SPARE_BYTE, 8'h5a, "load trigger");
    wr(ADDR_SPARE_BYTE, 8'hc3);
    wr(ADDR_X_BIAS_HIGH, 8'h3c);
    @(posedge clock_i);
    soft_reset_i <= 1'b1;
    @(posedge clock_i);
    soft_reset_i <= 1'b0;
    wait_idle();
    rd(ADDR_SPARE_BYTE, 8'h5a, "soft reset spare");
    rd(ADDR_X_BIAS_HIGH, img[0], "soft reset bias");
  endtask
  initial begin
    t_reset_load();
    t_readwrite();
    t_bias();
    t_self_test();
    t_load_soft();
    complete_run();
  end
endmodule
